// >>> hdl/pwmtc_defs.svh
// pwm timer channel 0: register map, field positions and reset values
// assumes the plain register port of pwmtc_top (8-bit address, 16-bit data)
`ifndef PWMTC_DEFS_SVH
`define PWMTC_DEFS_SVH
// register addresses
`define PWMTC_A_CLK_GATE  8'h00
`define PWMTC_A_START     8'h01
`define PWMTC_A_IRQ_MASK  8'h02
`define PWMTC_A_IRQ_FLAG  8'h03
`define PWMTC_A_PRIO_LOW  8'h04
`define PWMTC_A_PRIO_HIGH 8'h05
`define PWMTC_A_MODE      8'h06
`define PWMTC_A_PIN_FUNC  8'h07
`define PWMTC_A_OUT_DIS   8'h08
`define PWMTC_A_INIT_LVL  8'h09
`define PWMTC_A_CNT_CTRL  8'h0a
`define PWMTC_A_CMP_IEN   8'h0b
`define PWMTC_A_CMP_STAT  8'h0c
`define PWMTC_A_COUNTER   8'h0d
// general registers a..d sit at 8'h10..8'h13, low two bits pick one
`define PWMTC_GR_PAGE     6'h04
// field positions
`define PWMTC_B_GATE      4
`define PWMTC_B_START     0
`define PWMTC_B_MODE_SEL  2
`define PWMTC_B_IRQ       1
`define PWMTC_B_BUF_C     4
`define PWMTC_B_BUF_D     5
`define PWMTC_B_SYNC      0
`define PWMTC_B_CCLR_LSB  5
// reset values and encodings
`define PWMTC_R_OUT_DIS   4'hf
`define PWMTC_R_IRQ_MASK  1'h1
`define PWMTC_R_PRIO      2'h3
`define PWMTC_R_GR        16'hffff
`define PWMTC_CCLR_MATCH_A 3'h1
`endif

// >>> hdl/pwmtc_pkg.sv
// pwm timer channel 0: shared types
// assumes pwmtc_defs.svh holds every number
package pwmtc_pkg;
   typedef logic [7:0] pwmtc_addr_t;
   // behaviour of one timer pin
   typedef enum logic {
      PWMTC_PIN_CMP,
      PWMTC_PIN_PWM
   } pwmtc_pin_mode_t;
endpackage : pwmtc_pkg

// >>> hdl/pwmtc_counter.sv
// pwm timer channel 0: up counter with four compare matches
// assumes the count source is core_clk_i and hold_i is synchronous
`timescale 1ns/1ps
module pwmtc_counter #(
   parameter int W = 16
) (
   input  wire logic         core_clk_i,
   input  wire logic         resetn_i,
   input  wire logic         hold_i,
   input  wire logic         run_i,
   input  wire logic         clear_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] load_val_i,
   input  wire logic [W-1:0] cmp_a_i,
   input  wire logic [W-1:0] cmp_b_i,
   input  wire logic [W-1:0] cmp_c_i,
   input  wire logic [W-1:0] cmp_d_i,
   output logic      [W-1:0] count_o,
   output logic      [3:0]   match_o
);
   logic [W-1:0] count_ff;

   // a match only counts while running, so a stopped timer raises no event
   assign match_o = {4{run_i}} & {count_ff == cmp_d_i, count_ff == cmp_c_i,
                                  count_ff == cmp_b_i, count_ff == cmp_a_i};
   assign count_o = count_ff;

   // software load beats the clear so a written value is never lost
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_ff <= '0;
      end else if (hold_i) begin
         count_ff <= '0;
      end else if (load_i) begin
         count_ff <= load_val_i;
      end else if (clear_i) begin
         count_ff <= '0;
      end else if (run_i) begin
         count_ff <= count_ff + 1'b1;
      end
   end
endmodule : pwmtc_counter

// >>> hdl/pwmtc_pin.sv
// pwm timer channel 0: level of one timer pin
// assumes set_i is the period match and clr_i the pin's own match
`timescale 1ns/1ps
module pwmtc_pin (
   input  wire logic                       core_clk_i,
   input  wire logic                       resetn_i,
   input  wire logic                       hold_i,
   input  wire logic                       init_i,
   input  wire logic                       init_lvl_i,
   input  wire pwmtc_pkg::pwmtc_pin_mode_t mode_i,
   input  wire logic                       set_i,
   input  wire logic                       clr_i,
   output logic                            pin_o
);
   import pwmtc_pkg::*;
   logic pin_ff;

   assign pin_o = pin_ff;

   // pwm: active at the period match, inactive at the own match;
   // compare: toggle at the own match. the own match wins a tie, so
   // a duty register equal to the period gives a constant inactive pin
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_ff <= 1'b0;
      end else if (hold_i) begin
         pin_ff <= 1'b0;
      end else if (init_i) begin
         pin_ff <= init_lvl_i;
      end else begin
         case (mode_i)
            PWMTC_PIN_PWM: begin
               if (clr_i) begin
                  pin_ff <= 1'b0;
               end else if (set_i) begin
                  pin_ff <= 1'b1;
               end
            end
            PWMTC_PIN_CMP: begin
               if (clr_i) begin
                  pin_ff <= ~pin_ff;
               end
            end
            default: pin_ff <= pin_ff;
         endcase
      end
   end
endmodule : pwmtc_pin

// >>> hdl/pwmtc_top.sv
// pwm timer channel 0: clock gate, start control, interrupt request,
// buffer and pin function selection around one 16-bit counter
// assumes a same-clock register master and count source = core_clk_i
//
// Behaviour
// - gate off: stop, ignore timer writes, hold reset
// - gate on: timer runs, registers read/write
// - start bit stops or starts the counter
// - mode select: stop or continue at match a
// - mask bit blocks servicing of the interrupt
// - request flag pending; writing 0 clears
// - two-bit priority, level 0 highest
// - c register: general or buffer for a
// - d register: general or buffer for b
// - sync bit: channels independent or synchronous
// - d and c pins: compare or pwm
// - b pin: compare or pwm
// - clear select 001 clears at match a
// - initial level: inactive or active at start
// - output disable returns pin to port
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`include "pwmtc_defs.svh"
module pwmtc_top #(
   parameter int W = 16
) (
   input  wire logic                   core_clk_i,
   input  wire logic                   resetn_i,
   input  wire pwmtc_pkg::pwmtc_addr_t addr_i,
   input  wire logic [W-1:0]           wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   input  wire logic                   ch1_clear_i,
   output logic      [W-1:0]           rdata_o,
   output logic                        irq_o,
   output logic      [1:0]             irq_prio_o,
   output logic      [3:0]             pin_o,
   output logic      [3:0]             pin_oe_o,
   output logic                        sync_clear_o
);
   import pwmtc_pkg::*;

   // interrupt controller side, not part of the gated timer
   logic            gate_ff;
   logic            mk_ff;
   logic            if_ff;
   logic [1:0]      pr_ff;
   logic            irq_ff;
   logic [1:0]      prio_ff;
   // timer side, held in reset while the gate is off, except the read path
   logic            start_ff;
   logic            mode_ff;
   logic            bfc_ff;
   logic            bfd_ff;
   logic            sync_ff;
   logic [2:0]      pwm_ff;
   logic [3:0]      dis_ff;
   logic [3:0]      lvl_ff;
   logic [2:0]      cclr_ff;
   logic [3:0]      ier_ff;
   logic [3:0]      imf_ff;
   logic [W-1:0]    gr_ff [4];
   logic [3:0]      oe_ff;
   logic            sclr_ff;
   logic [W-1:0]    rdata_ff;
   logic [W-1:0]    rd_mux;
   // internal wires
   logic            hold;
   logic            twr;
   logic            gr_hit;
   logic [W-1:0]    count;
   logic [3:0]      match;
   logic            cnt_clear;
   logic            start_pulse;
   logic [3:0]      pwm_sel;
   pwmtc_pin_mode_t pin_mode [4];
   logic [3:0]      pin_lvl;

   // the whole timer sits in reset and ignores writes while ungated
   assign hold   = ~gate_ff;
   assign twr    = wr_i & gate_ff;
   assign gr_hit = (addr_i[7:2] == `PWMTC_GR_PAGE);

   // a write of 1 to a stopped counter loads the initial pin levels
   assign start_pulse = twr & (addr_i == `PWMTC_A_START)
                        & wdata_i[`PWMTC_B_START] & ~start_ff;

   // only the clear-at-a encoding clears locally; the other channel may
   // clear this one too when the two run synchronously
   assign cnt_clear = (match[0] & (cclr_ff == `PWMTC_CCLR_MATCH_A))
                      | (ch1_clear_i & sync_ff);

   // pin a has no pwm select and always behaves as compare
   assign pwm_sel = {pwm_ff, 1'b0};

   // peripheral clock gate, survives the timer reset it controls
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gate_ff <= 1'b0;
      end else if (wr_i && addr_i == `PWMTC_A_CLK_GATE) begin
         gate_ff <= wdata_i[`PWMTC_B_GATE];
      end
   end

   // count start; software write beats the hardware stop at match a
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         start_ff <= 1'b0;
         mode_ff  <= 1'b0;
      end else if (hold) begin
         start_ff <= 1'b0;
         mode_ff  <= 1'b0;
      end else if (twr && addr_i == `PWMTC_A_START) begin
         start_ff <= wdata_i[`PWMTC_B_START];
         mode_ff  <= wdata_i[`PWMTC_B_MODE_SEL];
      end else if (match[0] && !mode_ff) begin
         start_ff <= 1'b0;
      end
   end

   // mode, pin function, output disable, initial level, clear select
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bfc_ff  <= 1'b0;
         bfd_ff  <= 1'b0;
         sync_ff <= 1'b0;
         pwm_ff  <= '0;
         dis_ff  <= `PWMTC_R_OUT_DIS;
         lvl_ff  <= '0;
         cclr_ff <= '0;
         ier_ff  <= '0;
      end else if (hold) begin
         bfc_ff  <= 1'b0;
         bfd_ff  <= 1'b0;
         sync_ff <= 1'b0;
         pwm_ff  <= '0;
         dis_ff  <= `PWMTC_R_OUT_DIS;
         lvl_ff  <= '0;
         cclr_ff <= '0;
         ier_ff  <= '0;
      end else if (twr) begin
         case (addr_i)
            `PWMTC_A_MODE: begin
               bfc_ff  <= wdata_i[`PWMTC_B_BUF_C];
               bfd_ff  <= wdata_i[`PWMTC_B_BUF_D];
               sync_ff <= wdata_i[`PWMTC_B_SYNC];
            end
            `PWMTC_A_PIN_FUNC: pwm_ff  <= wdata_i[2:0];
            `PWMTC_A_OUT_DIS:  dis_ff  <= wdata_i[3:0];
            `PWMTC_A_INIT_LVL: lvl_ff  <= wdata_i[3:0];
            `PWMTC_A_CNT_CTRL: cclr_ff <= wdata_i[`PWMTC_B_CCLR_LSB +: 3];
            `PWMTC_A_CMP_IEN:  ier_ff  <= wdata_i[3:0];
            default: ;
         endcase
      end
   end

   // general registers; c and d feed a and b at the period match when
   // buffered, so software can change duty without a glitched period
   for (genvar g = 0; g < 4; g++) begin : g_gr
      always_ff @(posedge core_clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            gr_ff[g] <= `PWMTC_R_GR;
         end else if (hold) begin
            gr_ff[g] <= `PWMTC_R_GR;
         end else if (twr && gr_hit && addr_i[1:0] == 2'(g)) begin
            gr_ff[g] <= wdata_i;
         end else if (g == 0 && bfc_ff && match[0]) begin
            gr_ff[g] <= gr_ff[2];
         end else if (g == 1 && bfd_ff && match[0]) begin
            gr_ff[g] <= gr_ff[3];
         end
      end
   end

   // compare match status: sticky, write one to clear, a match wins
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         imf_ff <= '0;
      end else if (hold) begin
         imf_ff <= '0;
      end else if (twr && addr_i == `PWMTC_A_CMP_STAT) begin
         imf_ff <= (imf_ff & ~wdata_i[3:0]) | match;
      end else begin
         imf_ff <= imf_ff | match;
      end
   end

   // mask and priority live outside the timer, so the gate leaves them
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mk_ff <= `PWMTC_R_IRQ_MASK;
         pr_ff <= `PWMTC_R_PRIO;
      end else if (wr_i) begin
         case (addr_i)
            `PWMTC_A_IRQ_MASK:  mk_ff    <= wdata_i[`PWMTC_B_IRQ];
            `PWMTC_A_PRIO_LOW:  pr_ff[0] <= wdata_i[`PWMTC_B_IRQ];
            `PWMTC_A_PRIO_HIGH: pr_ff[1] <= wdata_i[`PWMTC_B_IRQ];
            default: ;
         endcase
      end
   end

   // request flag: an enabled match sets it even in the clearing cycle
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         if_ff <= 1'b0;
      end else if (|(match & ier_ff)) begin
         if_ff <= 1'b1;
      end else if (wr_i && addr_i == `PWMTC_A_IRQ_FLAG) begin
         if_ff <= wdata_i[`PWMTC_B_IRQ];
      end
   end

   // the mask only blocks servicing; the flag keeps pending underneath
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_ff  <= 1'b0;
         prio_ff <= `PWMTC_R_PRIO;
      end else begin
         irq_ff  <= if_ff & ~mk_ff;
         prio_ff <= pr_ff;
      end
   end

   // pin drive enable: disabled pins go back to the general port
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         oe_ff <= '0;
      end else begin
         oe_ff <= {4{gate_ff}} & ~dis_ff;
      end
   end

   // clear event offered to the other channel in synchronous mode
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sclr_ff <= 1'b0;
      end else begin
         sclr_ff <= sync_ff & match[0] &
                    (cclr_ff == `PWMTC_CCLR_MATCH_A);
      end
   end

   // read mux; unmapped addresses and unused bits read as zero
   always_comb begin
      rd_mux = '0;
      case (addr_i)
         `PWMTC_A_CLK_GATE:  rd_mux[`PWMTC_B_GATE] = gate_ff;
         `PWMTC_A_START: begin
            rd_mux[`PWMTC_B_START]    = start_ff;
            rd_mux[`PWMTC_B_MODE_SEL] = mode_ff;
         end
         `PWMTC_A_IRQ_MASK:  rd_mux[`PWMTC_B_IRQ] = mk_ff;
         `PWMTC_A_IRQ_FLAG:  rd_mux[`PWMTC_B_IRQ] = if_ff;
         `PWMTC_A_PRIO_LOW:  rd_mux[`PWMTC_B_IRQ] = pr_ff[0];
         `PWMTC_A_PRIO_HIGH: rd_mux[`PWMTC_B_IRQ] = pr_ff[1];
         `PWMTC_A_MODE: begin
            rd_mux[`PWMTC_B_BUF_C] = bfc_ff;
            rd_mux[`PWMTC_B_BUF_D] = bfd_ff;
            rd_mux[`PWMTC_B_SYNC]  = sync_ff;
         end
         `PWMTC_A_PIN_FUNC:  rd_mux[2:0] = pwm_ff;
         `PWMTC_A_OUT_DIS:   rd_mux[3:0] = dis_ff;
         `PWMTC_A_INIT_LVL:  rd_mux[3:0] = lvl_ff;
         `PWMTC_A_CNT_CTRL:  rd_mux[`PWMTC_B_CCLR_LSB +: 3] = cclr_ff;
         `PWMTC_A_CMP_IEN:   rd_mux[3:0] = ier_ff;
         `PWMTC_A_CMP_STAT:  rd_mux[3:0] = imf_ff;
         `PWMTC_A_COUNTER:   rd_mux = count;
         default: begin
            if (gr_hit) begin
               rd_mux = gr_ff[addr_i[1:0]];
            end
         end
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_ff <= '0;
      end else if (rd_i) begin
         rdata_ff <= rd_mux;
      end else begin
         rdata_ff <= '0;
      end
   end

   pwmtc_counter #(
      .W (W)
   ) u_counter (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .hold_i     (hold),
      .run_i      (start_ff),
      .clear_i    (cnt_clear),
      .load_i     (twr && addr_i == `PWMTC_A_COUNTER),
      .load_val_i (wdata_i),
      .cmp_a_i    (gr_ff[0]),
      .cmp_b_i    (gr_ff[1]),
      .cmp_c_i    (gr_ff[2]),
      .cmp_d_i    (gr_ff[3]),
      .count_o    (count),
      .match_o    (match)
   );

   // one pin per general register; period set comes from match a
   for (genvar p = 0; p < 4; p++) begin : g_pin
      assign pin_mode[p] = pwm_sel[p] ? PWMTC_PIN_PWM : PWMTC_PIN_CMP;
      pwmtc_pin u_pin (
         .core_clk_i (core_clk_i),
         .resetn_i   (resetn_i),
         .hold_i     (hold),
         .init_i     (start_pulse),
         .init_lvl_i (lvl_ff[p]),
         .mode_i     (pin_mode[p]),
         .set_i      (match[0]),
         .clr_i      (match[p]),
         .pin_o      (pin_lvl[p])
      );
   end

   assign rdata_o      = rdata_ff;
   assign irq_o        = irq_ff;
   assign irq_prio_o   = prio_ff;
   assign pin_o        = pin_lvl;
   assign pin_oe_o     = oe_ff;
   assign sync_clear_o = sclr_ff;
endmodule : pwmtc_top

// >>> tb/pwmtc_props.sv
// checker for pwmtc_top: bus answer timing, interrupt and pin outputs
// assumes one clock domain and the register map of pwmtc_defs.svh
`timescale 1ns/1ps
`include "pwmtc_defs.svh"
module pwmtc_props #(
   parameter int W = 16
) (
   input wire logic                   core_clk_i,
   input wire logic                   resetn_i,
   input wire pwmtc_pkg::pwmtc_addr_t addr_i,
   input wire logic [W-1:0]           wdata_i,
   input wire logic                   wr_i,
   input wire logic                   rd_i,
   input wire logic                   ch1_clear_i,
   input wire logic [W-1:0]           rdata_o,
   input wire logic                   irq_o,
   input wire logic [1:0]             irq_prio_o,
   input wire logic [3:0]             pin_o,
   input wire logic [3:0]             pin_oe_o,
   input wire logic                   sync_clear_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   // steps of a gate-off write and the quiet pins that must follow, and of a mask-set write
   sequence s_gate_off;
      wr_i && addr_i == `PWMTC_A_CLK_GATE && !wdata_i[`PWMTC_B_GATE];
   endsequence
   sequence s_pins_quiet;
      pin_oe_o == 4'h0 && pin_o == 4'h0;
   endsequence
   sequence s_mask_set;
      wr_i && addr_i == `PWMTC_A_IRQ_MASK && wdata_i[`PWMTC_B_IRQ];
   endsequence

   a_gate_off_quiet: assert property (s_gate_off |-> ##2 s_pins_quiet)
      else $error("pins still active after clock gate off");
   a_mask_blocks: assert property (s_mask_set |-> ##2 !irq_o)
      else $error("interrupt not blocked by mask");
   a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(wr_i, 2)
      && $past(addr_i, 2) inside {`PWMTC_A_IRQ_MASK, `PWMTC_A_IRQ_FLAG})
      else $error("interrupt dropped without flag or mask write");
   a_prio_cause: assert property ($changed(irq_prio_o) |->
      $past(wr_i, 2) && $past(addr_i, 2)
      inside {`PWMTC_A_PRIO_LOW, `PWMTC_A_PRIO_HIGH})
      else $error("priority changed without priority write");
   a_oe_cause: assert property ($changed(pin_oe_o) |-> $past(wr_i, 2)
      && $past(addr_i, 2) inside {`PWMTC_A_CLK_GATE, `PWMTC_A_OUT_DIS})
      else $error("pin enables changed without enable write");
   a_read_window: assert property (!$past(rd_i) |-> rdata_o == '0)
      else $error("read data outside the answer cycle");
   a_unmapped_zero: assert property (rd_i && addr_i == 8'hff
      |=> rdata_o == '0)
      else $error("unmapped read not zero");
   a_reset_state: assert property ($rose(resetn_i) |->
      irq_prio_o == 2'h3 && !irq_o && pin_oe_o == 4'h0)
      else $error("outputs wrong after reset");
endmodule : pwmtc_props

bind pwmtc_top pwmtc_props #(.W(W)) u_props (
   .core_clk_i  (core_clk_i),
   .resetn_i    (resetn_i),
   .addr_i      (addr_i),
   .wdata_i     (wdata_i),
   .wr_i        (wr_i),
   .rd_i        (rd_i),
   .ch1_clear_i (ch1_clear_i),
   .rdata_o     (rdata_o),
   .irq_o       (irq_o),
   .irq_prio_o  (irq_prio_o),
   .pin_o       (pin_o),
   .pin_oe_o    (pin_oe_o),
   .sync_clear_o(sync_clear_o)
);

// >>> tb/pwm_timer_channel_setup_tb.sv
// testbench for pwmtc_top: registers, interrupt, counting and pins
// assumes pwmtc_props is bound in its own file; clock is 100 MHz
`timescale 1ns/1ps
`include "pwmtc_defs.svh"
module pwm_timer_channel_setup_tb;
   import pwmtc_pkg::*;
   localparam pwmtc_addr_t gr_a = {`PWMTC_GR_PAGE, 2'd0};
   localparam pwmtc_addr_t gr_b = {`PWMTC_GR_PAGE, 2'd1};
   localparam pwmtc_addr_t gr_c = {`PWMTC_GR_PAGE, 2'd2};
   localparam pwmtc_addr_t gr_d = {`PWMTC_GR_PAGE, 2'd3};
   logic        core_clk_i;
   logic        resetn_i;
   pwmtc_addr_t addr_i;
   logic [15:0] wdata_i;
   logic        wr_i;
   logic        rd_i;
   logic        ch1_clear_i;
   logic [15:0] rdata_o;
   logic        irq_o;
   logic [1:0]  irq_prio_o;
   logic [3:0]  pin_o;
   logic [3:0]  pin_oe_o;
   logic        sync_clear_o;
   logic [15:0] seen;
   int          num_errors;
   int          check_count;

   pwmtc_top #(.W(16)) i_dut (
      .core_clk_i  (core_clk_i),
      .resetn_i    (resetn_i),
      .addr_i      (addr_i),
      .wdata_i     (wdata_i),
      .wr_i        (wr_i),
      .rd_i        (rd_i),
      .ch1_clear_i (ch1_clear_i),
      .rdata_o     (rdata_o),
      .irq_o       (irq_o),
      .irq_prio_o  (irq_prio_o),
      .pin_o       (pin_o),
      .pin_oe_o    (pin_oe_o),
      .sync_clear_o(sync_clear_o)
   );

   // free-running 100 MHz clock
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   task automatic check(input string what, input logic [15:0] got,
                        input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   // #1 lets the edge's updates land before anything is sampled
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : cyc

   // reset is asserted and released on a rising edge, never between
   task automatic do_reset();
      @(posedge core_clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      resetn_i <= 1'b1;
   endtask : do_reset

   task automatic wr(input pwmtc_addr_t a, input logic [15:0] d);
      @(posedge core_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge core_clk_i);
      wr_i    <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input pwmtc_addr_t a);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge core_clk_i);
      rd_i   <= 1'b0;
      #1;
      seen = rdata_o;
   endtask : rd

   task automatic rdchk(input pwmtc_addr_t a, input logic [15:0] exp,
                        input string what);
      rd(a);
      check(what, seen, exp);
   endtask : rdchk

   // bounded wait for the interrupt level or the sync clear pulse
   task automatic wait_hi(input bit use_sync, input string what);
      int n;
      n = 0;
      while (n < 64 && (use_sync ? sync_clear_o : irq_o) !== 1'b1) begin
         cyc(1);
         n++;
      end
      check(what, {15'h0, n < 64}, 16'h0001);
      if (n == 64)
         complete_run();
   endtask : wait_hi

   task automatic t_reset_values();
      check("prio_rst", {14'h0, irq_prio_o}, 16'h0003);
      rdchk(`PWMTC_A_IRQ_MASK, 16'h0002, "mask_rst");
      rdchk(`PWMTC_A_PRIO_HIGH, 16'h0002, "prhi_rst");
      rdchk(`PWMTC_A_CLK_GATE, 16'h0000, "gate_rst");
      rdchk(8'hff, 16'h0000, "unmapped");
      wr(gr_a, 16'h0005);
      wr(`PWMTC_A_CLK_GATE, 16'h0010);
      rdchk(gr_a, 16'hffff, "gr_a_gated");
      wr(gr_a, 16'h0005);
      rdchk(gr_a, 16'h0005, "gr_a_open");
      wr(`PWMTC_A_OUT_DIS, 16'h0001);
      cyc(2);
      check("oe", {12'h0, pin_oe_o}, 16'h000e);
   endtask : t_reset_values

   task automatic t_priority();
      for (int l = 0; l < 4; l++) begin
         wr(`PWMTC_A_PRIO_LOW, {14'h0, l[0], 1'b0});
         wr(`PWMTC_A_PRIO_HIGH, {14'h0, l[1], 1'b0});
         cyc(2);
         check("prio", {14'h0, irq_prio_o}, l[15:0]);
      end
   endtask : t_priority

   task automatic t_count_mode();
      wr(`PWMTC_A_CNT_CTRL, 16'h0020);
      wr(gr_a, 16'h0004);
      wr(`PWMTC_A_START, 16'h0001);
      cyc(20);
      rdchk(`PWMTC_A_START, 16'h0000, "stop_at_a");
      rdchk(`PWMTC_A_COUNTER, 16'h0000, "cnt_stop");
      wr(`PWMTC_A_START, 16'h0005);
      cyc(20);
      rdchk(`PWMTC_A_START, 16'h0005, "continue");
      wr(`PWMTC_A_START, 16'h0004);
      rd(`PWMTC_A_COUNTER);
      check("cnt_range", {15'h0, seen <= 16'h0004}, 16'h0001);
      cyc(3);
      rdchk(`PWMTC_A_COUNTER, seen, "cnt_held");
   endtask : t_count_mode

   task automatic t_irq();
      wr(`PWMTC_A_CMP_IEN, 16'h0001);
      wr(`PWMTC_A_IRQ_MASK, 16'h0000);
      wr(`PWMTC_A_START, 16'h0005);
      wait_hi(1'b0, "irq_match");
      wr(`PWMTC_A_START, 16'h0004);
      rdchk(`PWMTC_A_IRQ_FLAG, 16'h0002, "flag_set");
      rdchk(`PWMTC_A_CMP_STAT, 16'h0001, "stat_set");
      wr(`PWMTC_A_CMP_STAT, 16'h0001);
      rdchk(`PWMTC_A_CMP_STAT, 16'h0000, "stat_clr");
      wr(`PWMTC_A_IRQ_FLAG, 16'h0000);
      cyc(2);
      check("irq_clr", {15'h0, irq_o}, 16'h0000);
      wr(`PWMTC_A_IRQ_FLAG, 16'h0002);
      cyc(2);
      check("irq_sw", {15'h0, irq_o}, 16'h0001);
      wr(`PWMTC_A_IRQ_MASK, 16'h0002);
      cyc(2);
      check("irq_mask", {15'h0, irq_o}, 16'h0000);
      wr(`PWMTC_A_IRQ_FLAG, 16'h0000);
   endtask : t_irq

   // pwm high time per period is own match + 1 clocks, period gr_a + 1
   task automatic t_pwm();
      int   hb;
      int   hc;
      int   hd;
      int   tg;
      int         ta;
      logic [3:0] lp;
      hb = 0;
      hc = 0;
      hd = 0;
      tg = 0;
      ta = 0;
      wr(gr_a, 16'h0009);
      wr(gr_b, 16'h0002);
      wr(gr_c, 16'h0004);
      wr(gr_d, 16'h0006);
      wr(`PWMTC_A_PIN_FUNC, 16'h0007);
      wr(`PWMTC_A_INIT_LVL, 16'h0000);
      wr(`PWMTC_A_START, 16'h0005);
      cyc(12);
      for (int i = 0; i < 30; i++) begin
         cyc(1);
         hb += pin_o[1];
         hc += pin_o[2];
         hd += pin_o[3];
      end
      check("pwm_b", hb[15:0], 16'h0009);
      check("pwm_c", hc[15:0], 16'h000f);
      check("pwm_d", hd[15:0], 16'h0015);
      wr(`PWMTC_A_PIN_FUNC, 16'h0003);
      cyc(10);
      lp = pin_o;
      for (int i = 0; i < 30; i++) begin
         cyc(1);
         tg += (pin_o[3] !== lp[3]);
         ta += (pin_o[0] !== lp[0]);
         lp = pin_o;
      end
      check("cmp_d", tg[15:0], 16'h0003);
      check("cmp_a", ta[15:0], 16'h0003);
      wr(gr_b, 16'h0008);
      for (int v = 1; v >= 0; v--) begin
         wr(`PWMTC_A_START, 16'h0004);
         wr(`PWMTC_A_COUNTER, 16'h0000);
         wr(`PWMTC_A_INIT_LVL, {14'h0, v[0], 1'b0});
         wr(`PWMTC_A_START, 16'h0005);
         cyc(1);
         check("init_b", {15'h0, pin_o[1]}, v[15:0]);
      end
      wr(`PWMTC_A_START, 16'h0004);
   endtask : t_pwm

   task automatic t_buffer();
      wr(`PWMTC_A_COUNTER, 16'h0000);
      wr(gr_a, 16'h0005);
      wr(gr_c, 16'h0003);
      wr(gr_d, 16'h0001);
      wr(`PWMTC_A_MODE, 16'h0030);
      wr(`PWMTC_A_START, 16'h0005);
      cyc(12);
      wr(`PWMTC_A_MODE, 16'h0000);
      wr(gr_c, 16'h0007);
      cyc(12);
      wr(`PWMTC_A_START, 16'h0004);
      rdchk(gr_a, 16'h0003, "buf_c");
      rdchk(gr_b, 16'h0001, "buf_d");
   endtask : t_buffer

   // a pulse from the other channel clears only while synchronised
   task automatic t_sync();
      for (int s = 1; s >= 0; s--) begin
         wr(`PWMTC_A_MODE, {15'h0, s[0]});
         if (s == 1) begin
            wr(`PWMTC_A_START, 16'h0005);
            wait_hi(1'b1, "sync_pulse");
            wr(`PWMTC_A_START, 16'h0004);
         end
         wr(`PWMTC_A_COUNTER, 16'h0033);
         @(posedge core_clk_i);
         ch1_clear_i <= 1'b1;
         @(posedge core_clk_i);
         ch1_clear_i <= 1'b0;
         rdchk(`PWMTC_A_COUNTER, s ? 16'h0000 : 16'h0033, "sync_clr");
      end
   endtask : t_sync

   // gate off puts the timer back in reset and lets go of the pins;
   // the gate is reopened so the final reset has something to clear
   task automatic t_gate_off();
      wr(`PWMTC_A_CLK_GATE, 16'h0000);
      rdchk(gr_a, 16'hffff, "gr_a_held");
      check("pins_off", {8'h0, pin_oe_o, pin_o}, 16'h0000);
      wr(`PWMTC_A_CLK_GATE, 16'h0010);
   endtask : t_gate_off

   // main sequence, ending with a reset of the stopped timer after the gate is reopened
   initial begin
      resetn_i    = 1'b0;
      addr_i      = '0;
      wdata_i     = '0;
      wr_i        = 1'b0;
      rd_i        = 1'b0;
      ch1_clear_i = 1'b0;
      num_errors  = 0;
      check_count = 0;
      do_reset();
      t_reset_values();
      t_priority();
      t_count_mode();
      t_irq();
      t_pwm();
      t_buffer();
      t_sync();
      t_gate_off();
      do_reset();
      rdchk(`PWMTC_A_CLK_GATE, 16'h0000, "gate_rerst");
      complete_run();
   end
endmodule : pwm_timer_channel_setup_tb
